// File: logic/fdd_pkg.sv
// Purpose: Shared constants and types for the fabric domain identifier distribution block
// Assumes: Frames are already parsed into single-cycle request/answer events per E_Port
// Notes:   Widths and codes are fixed
package fdd_pkg;
   localparam int NPORT    = 4;
   localparam int PW       = 2;
   localparam int DOM_W    = 8;
   localparam int NDOM     = 256;
   localparam logic [7:0]  MGR_PRIO      = 8'h01;
   localparam logic [7:0]  PRIO_RST      = 8'hFF;
   localparam logic [7:0]  ID_FIRST      = 8'h01;
   localparam logic [7:0]  ID_LAST       = 8'hEF;
   localparam logic [7:0]  RJT_UNABLE    = 8'h09;
   localparam logic [7:0]  EXPL_NO_ID    = 8'h01;

   typedef enum logic [2:0] {
      FDD_ANS_NONE = 3'b000,
      FDD_ANS_ACC  = 3'b001,
      FDD_ANS_RJT  = 3'b010
   } fdd_ans_t;

   // One outbound request or reply, addressed to one E_Port
   typedef struct packed {
      logic              aai;
      logic              rdi;
      logic              efp;
      logic              rcf;
      logic              bf;
      fdd_ans_t          ans;
      logic [7:0]        rjt_reason;
      logic [7:0]        rjt_expl;
      logic [DOM_W-1:0]  dom;
      logic [PW-1:0]     port;
   } fdd_tx_t;

   // One inbound frame event from an E_Port
   typedef struct packed {
      logic              aai;
      logic              rdi;
      logic              acc;
      logic [DOM_W-1:0]  dom;
      logic [PW-1:0]     port;
   } fdd_rx_t;

   typedef enum logic [2:0] {
      FDD_IDLE   = 3'b000,
      FDD_SELF   = 3'b001,
      FDD_AAI    = 3'b010,
      FDD_SERVE  = 3'b011,
      FDD_WAIT   = 3'b100,
      FDD_GRANTD = 3'b101
   } fdd_state_t;
endpackage : fdd_pkg

// File: logic/fdd_pool.sv
// Purpose: Identifier pool lookup: free check and lowest free pick
// Assumes: Bitmap bit n set means identifier n granted
// Notes:   Purely combinational
`timescale 1ns/100ps
`default_nettype none
module fdd_pool
   import fdd_pkg::*;
(
   input  wire logic [NDOM-1:0]  map_i,
   input  wire logic [DOM_W-1:0] want_i,
   output logic                  want_free_o,
   output logic                  any_free_o,
   output logic [DOM_W-1:0]      pick_o
);
   always_comb begin
      want_free_o = (want_i >= ID_FIRST) && (want_i <= ID_LAST) && !map_i[want_i];
      any_free_o  = 1'b0;
      pick_o      = '0;
      // Highest index scanned first so the final value is the lowest free one
      for (int i = int'(ID_LAST); i >= int'(ID_FIRST); i--) begin
         if (!map_i[i]) begin
            any_free_o = 1'b1;
            pick_o     = DOM_W'(i);
         end
      end
   end
endmodule : fdd_pool
`default_nettype wire

// File: logic/fdd_isolate.sv
// Purpose: Per E_Port isolation state
// Assumes: Causes arrive as single-cycle pulses
// Notes:   Isolation gates Class N only
`timescale 1ns/100ps
`default_nettype none
module fdd_isolate (
   input  wire logic clk_i,
   input  wire logic sys_rst_i,
   input  wire logic param_bad_i,
   input  wire logic overlap_i,
   input  wire logic no_mgr_i,
   input  wire logic rcf_sent_i,
   output logic      iso_o,
   output logic      class_n_ok_o
);
   logic iso_reg;
   logic iso_next;

   always_comb begin
      iso_next = iso_reg;
      if (rcf_sent_i) begin
         iso_next = 1'b0;
      end
      // A fresh cause in the same cycle as an RCF keeps the port isolated
      if (param_bad_i) begin
         iso_next = 1'b1;
      end
      if (overlap_i) begin
         iso_next = 1'b1;
      end
      if (no_mgr_i) begin
         iso_next = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         iso_reg <= 1'b0;
      end else begin
         iso_reg <= iso_next;
      end
   end

   assign iso_o        = iso_reg;
   assign class_n_ok_o = !iso_reg;
endmodule : fdd_isolate
`default_nettype wire

// File: logic/fdd_core.sv
// Purpose: Domain identifier distribution for one switch, manager or requester
// Assumes: One inbound event per cycle; outbound events taken in the cycle shown
// Notes:   Relay tracks one outstanding downstream request at a time
`timescale 1ns/100ps
`default_nettype none
module fdd_core
   import fdd_pkg::*;
(
   input  wire logic                  clk_i,
   input  wire logic                  sys_rst_i,
   input  wire logic                  sel_done_i,
   input  wire logic                  is_principal_i,
   input  wire logic                  have_prior_i,
   input  wire logic [DOM_W-1:0]      prior_id_i,
   input  wire logic                  low_seen_i,
   input  wire logic [PW-1:0]         low_port_i,
   input  wire fdd_rx_t               rx_i,
   input  wire logic                  disruptive_i,
   input  wire logic [NPORT-1:0]      param_bad_i,
   input  wire logic [NPORT-1:0]      overlap_i,
   input  wire logic                  no_mgr_i,
   input  wire logic [NPORT-1:0]      rcf_cancel_i,
   output fdd_tx_t                    tx_o,
   output logic                       tx_valid_o,
   output logic                       is_mgr_o,
   output logic [7:0]                 prio_o,
   output logic [DOM_W-1:0]           my_id_o,
   output logic                       id_valid_o,
   output logic                       assign_ports_o,
   output logic [NDOM-1:0]            dom_map_o,
   output logic [NPORT-1:0]           down_link_o,
   output logic [NPORT-1:0]           iso_o,
   output logic [NPORT-1:0]           class_n_ok_o
);
   ////////////////////////////////////////////////////////////////////////
   // State
   fdd_state_t             st_reg,     st_next;
   logic                   mgr_reg,    mgr_next;
   logic [7:0]             prio_reg,   prio_next;
   logic [DOM_W-1:0]       id_reg,     id_next;
   logic                   idv_reg,    idv_next;
   logic [NDOM-1:0]        map_reg,    map_next;
   logic [NPORT-1:0]       down_reg,   down_next;
   logic [NPORT-1:0]       ackd_reg,   ackd_next;
   logic [PW-1:0]          up_reg,     up_next;
   logic [PW-1:0]          aai_ptr_reg, aai_ptr_next;
   logic                   relay_reg,  relay_next;
   logic [PW-1:0]          relay_port_reg, relay_port_next;
   logic                   own_rdi_reg, own_rdi_next;
   logic                   asg_reg,    asg_next;
   fdd_tx_t                tx_reg,     tx_next;
   logic                   txv_reg,    txv_next;
   // Per-port record of which identifier each requester holds
   logic [DOM_W-1:0]       held_reg [NPORT];
   logic [DOM_W-1:0]       held_next [NPORT];
   logic [NPORT-1:0]       hv_reg,     hv_next;

   logic                   want_free;
   logic                   any_free;
   logic [DOM_W-1:0]       pick;
   logic [DOM_W-1:0]       pool_want;

   // The prior identifier is only looked up while the manager grants itself
   assign pool_want = (st_reg == FDD_SELF) ? prior_id_i : rx_i.dom;

   fdd_pool u_pool (
      .map_i       (map_reg),
      .want_i      (pool_want),
      .want_free_o (want_free),
      .any_free_o  (any_free),
      .pick_o      (pick)
   );

   genvar g;
   generate
      for (g = 0; g < NPORT; g++) begin : g_iso
         fdd_isolate u_iso (
            .clk_i        (clk_i),
            .sys_rst_i    (sys_rst_i),
            .param_bad_i  (param_bad_i[g]),
            .overlap_i    (overlap_i[g]),
            .no_mgr_i     (no_mgr_i),
            .rcf_sent_i   (rcf_cancel_i[g]),
            .iso_o        (iso_o[g]),
            .class_n_ok_o (class_n_ok_o[g])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      st_next         = st_reg;
      mgr_next        = mgr_reg;
      prio_next       = prio_reg;
      id_next         = id_reg;
      idv_next        = idv_reg;
      map_next        = map_reg;
      down_next       = down_reg;
      ackd_next       = ackd_reg;
      up_next         = up_reg;
      aai_ptr_next    = aai_ptr_reg;
      relay_next      = relay_reg;
      relay_port_next = relay_port_reg;
      own_rdi_next    = own_rdi_reg;
      asg_next        = 1'b0;
      held_next       = held_reg;
      hv_next         = hv_reg;
      tx_next         = '0;
      txv_next        = 1'b0;

      if (low_seen_i && !mgr_reg) begin
         up_next = low_port_i;
      end

      // An acknowledgement can land while the AAI walk is still running,
      // so it is recorded outside the state machine
      if (rx_i.acc && (mgr_reg || rx_i.port != up_reg)
          && (st_reg == FDD_AAI || st_reg == FDD_SERVE || st_reg == FDD_GRANTD)) begin
         ackd_next[rx_i.port] = 1'b1;
      end

      // AAI is always answered; only the upstream one drives behaviour
      if (rx_i.aai) begin
         tx_next.ans  = FDD_ANS_ACC;
         tx_next.port = rx_i.port;
         txv_next     = 1'b1;
         if (!mgr_reg && rx_i.port == up_reg && !idv_reg && st_reg == FDD_IDLE) begin
            st_next = FDD_WAIT;
         end
      end

      unique case (st_reg)
         FDD_IDLE: begin
            if (sel_done_i && is_principal_i) begin
               mgr_next  = 1'b1;
               prio_next = MGR_PRIO;
               map_next  = '0;
               down_next = '0;
               hv_next   = '0;
               st_next   = FDD_SELF;
            end
         end
         FDD_SELF: begin
            // Reuse the old identifier only when it is still free
            id_next  = (have_prior_i && want_free) ? prior_id_i : pick;
            idv_next = 1'b1;
            map_next[(have_prior_i && want_free) ? prior_id_i : pick] = 1'b1;
            asg_next = 1'b1;
            tx_next.efp = 1'b1;
            tx_next.dom = (have_prior_i && want_free) ? prior_id_i : pick;
            txv_next     = 1'b1;
            aai_ptr_next = '0;
            ackd_next    = '0;
            st_next      = FDD_AAI;
         end
         FDD_AAI: begin
            if (!txv_next) begin
               // Skip the upstream link when not the manager
               if (mgr_reg || aai_ptr_reg != up_reg) begin
                  tx_next.aai  = 1'b1;
                  tx_next.port = aai_ptr_reg;
                  txv_next     = 1'b1;
               end
               aai_ptr_next = aai_ptr_reg + PW'(1);
               if (aai_ptr_reg == PW'(NPORT - 1)) begin
                  st_next = FDD_SERVE;
               end
            end
         end
         FDD_WAIT: begin
            if (!own_rdi_reg && !txv_next) begin
               tx_next.rdi  = 1'b1;
               // Zero asks the manager to choose any free identifier
               tx_next.dom  = have_prior_i ? prior_id_i : '0;
               tx_next.port = up_reg;
               txv_next     = 1'b1;
               own_rdi_next = 1'b1;
            end else if (rx_i.acc && rx_i.port == up_reg && own_rdi_reg) begin
               id_next      = rx_i.dom;
               idv_next     = 1'b1;
               asg_next     = 1'b1;
               own_rdi_next = 1'b0;
               aai_ptr_next = '0;
               st_next      = FDD_AAI;
            end
         end
         FDD_SERVE: begin
            // RDI is only taken on a port whose AAI has been acknowledged
            if (mgr_reg && rx_i.rdi && !txv_next && ackd_reg[rx_i.port]) begin
               down_next[rx_i.port] = 1'b1;
               tx_next.port = rx_i.port;
               txv_next     = 1'b1;
               if (hv_reg[rx_i.port] && held_reg[rx_i.port] == rx_i.dom) begin
                  tx_next.ans = FDD_ANS_ACC;
                  tx_next.dom = rx_i.dom;
                  // A repeat grant is still a grant, so the map goes out again
                  st_next     = FDD_GRANTD;
               end else if (hv_reg[rx_i.port]) begin
                  // One holder per E_Port: a different identifier there is a conflict
                  tx_next.bf  = !disruptive_i;
                  tx_next.rcf = disruptive_i;
               end else if (!any_free) begin
                  tx_next.ans        = FDD_ANS_RJT;
                  tx_next.rjt_reason = RJT_UNABLE;
                  tx_next.rjt_expl   = EXPL_NO_ID;
               end else begin
                  tx_next.ans = FDD_ANS_ACC;
                  tx_next.dom = (rx_i.dom != '0 && want_free) ? rx_i.dom : pick;
                  map_next[tx_next.dom] = 1'b1;
                  held_next[rx_i.port]  = tx_next.dom;
                  hv_next[rx_i.port]    = 1'b1;
                  st_next               = FDD_GRANTD;
               end
            end else if (!mgr_reg && rx_i.rdi && !txv_next && !relay_reg
                         && rx_i.port != up_reg && ackd_reg[rx_i.port]) begin
               // A second downstream RDI during an open relay is dropped
               down_next[rx_i.port] = 1'b1;
               relay_next      = 1'b1;
               relay_port_next = rx_i.port;
               tx_next.rdi     = 1'b1;
               tx_next.dom     = rx_i.dom;
               tx_next.port    = up_reg;
               txv_next        = 1'b1;
            end else if (!mgr_reg && relay_reg && rx_i.acc && rx_i.port == up_reg
                         && !txv_next) begin
               relay_next   = 1'b0;
               tx_next.ans  = FDD_ANS_ACC;
               tx_next.dom  = rx_i.dom;
               tx_next.port = relay_port_reg;
               txv_next     = 1'b1;
            end
         end
         FDD_GRANTD: begin
            // The whole map follows on dom_map_o; dom names the sender
            if (!txv_next) begin
               tx_next.efp = 1'b1;
               tx_next.dom = id_reg;
               txv_next    = 1'b1;
               st_next     = FDD_SERVE;
            end
         end
         default: st_next = FDD_IDLE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         st_reg         <= FDD_IDLE;
         mgr_reg        <= 1'b0;
         prio_reg       <= PRIO_RST;
         id_reg         <= '0;
         idv_reg        <= 1'b0;
         map_reg        <= '0;
         down_reg       <= '0;
         ackd_reg       <= '0;
         up_reg         <= '0;
         aai_ptr_reg    <= '0;
         relay_reg      <= 1'b0;
         relay_port_reg <= '0;
         own_rdi_reg    <= 1'b0;
         asg_reg        <= 1'b0;
         tx_reg         <= '0;
         txv_reg        <= 1'b0;
         hv_reg         <= '0;
         for (int i = 0; i < NPORT; i++) begin
            held_reg[i] <= '0;
         end
      end else begin
         st_reg         <= st_next;
         mgr_reg        <= mgr_next;
         prio_reg       <= prio_next;
         id_reg         <= id_next;
         idv_reg        <= idv_next;
         map_reg        <= map_next;
         down_reg       <= down_next;
         ackd_reg       <= ackd_next;
         up_reg         <= up_next;
         aai_ptr_reg    <= aai_ptr_next;
         relay_reg      <= relay_next;
         relay_port_reg <= relay_port_next;
         own_rdi_reg    <= own_rdi_next;
         asg_reg        <= asg_next;
         tx_reg         <= tx_next;
         txv_reg        <= txv_next;
         hv_reg         <= hv_next;
         held_reg       <= held_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs
   assign tx_o           = tx_reg;
   assign tx_valid_o     = txv_reg;
   assign is_mgr_o       = mgr_reg;
   assign prio_o         = prio_reg;
   assign my_id_o        = id_reg;
   assign id_valid_o     = idv_reg;
   assign assign_ports_o = asg_reg;
   assign dom_map_o      = map_reg;
   assign down_link_o    = down_reg;
endmodule : fdd_core
`default_nettype wire

// File: dv/fdd_peer.sv
// Purpose: Neighbour switches on the far side of the fdd_core E_Ports
// Assumes: One inbound event per cycle; queued events keep their order
// Notes:   Idle fields roll every cycle so a stale frame never looks valid
`timescale 1ns/100ps
`default_nettype none
module fdd_peer
   import fdd_pkg::*;
(
   input  wire logic             clk_i,
   input  wire logic             sys_rst_i,
   input  wire fdd_tx_t          tx_i,
   input  wire logic             tx_valid_i,
   input  wire logic             cmd_valid_i,
   input  wire fdd_rx_t          cmd_i,
   input  wire logic [DOM_W-1:0] gnt_dom_i,
   input  wire logic             slow_i,
   output fdd_rx_t               rx_o
);
   fdd_rx_t     q[$];
   logic [31:0] due[$];
   logic [31:0] cyc = '0;
   fdd_rx_t     ev;
   initial rx_o = '0;
   always @(posedge clk_i) begin
      cyc = cyc + 1;
      if (sys_rst_i) begin
         q.delete();
         due.delete();
      end else begin
         if (tx_valid_i && (tx_i.aai || tx_i.rdi)) begin
            // Acknowledge AAI, grant on RDI; slow mode delays it
            ev = '{aai: 1'h0, rdi: 1'h0, acc: 1'h1, dom: gnt_dom_i, port: tx_i.port};
            q.push_back(ev);
            due.push_back(cyc + (slow_i ? 4 : 1));
         end
         if (cmd_valid_i) begin
            q.push_back(cmd_i);
            due.push_back(cyc);
         end
      end
      ev = '{aai: 1'h0, rdi: 1'h0, acc: 1'h0, dom: cyc[7:0] ^ 8'hA5, port: cyc[1:0]};
      if (q.size() > 0 && due[0] <= cyc) begin
         ev = q.pop_front();
         void'(due.pop_front());
      end
      rx_o <= ev;
   end
endmodule : fdd_peer
`default_nettype wire

// File: dv/fdd_core_sva.sv
// Purpose: Port checker for fdd_core
// Assumes: Requests checked only after two cycles with no outbound event
// Notes:   Bound at the foot of this file
`timescale 1ns/100ps
`default_nettype none
module fdd_core_sva
   import fdd_pkg::*;
(
   input wire logic             clk_i,
   input wire logic             sys_rst_i,
   input wire logic             sel_done_i,
   input wire logic             is_principal_i,
   input wire logic             have_prior_i,
   input wire logic [DOM_W-1:0] prior_id_i,
   input wire logic             low_seen_i,
   input wire logic [PW-1:0]    low_port_i,
   input wire fdd_rx_t          rx_i,
   input wire logic             disruptive_i,
   input wire logic [NPORT-1:0] param_bad_i,
   input wire logic [NPORT-1:0] overlap_i,
   input wire logic             no_mgr_i,
   input wire logic [NPORT-1:0] rcf_cancel_i,
   input wire fdd_tx_t          tx_o,
   input wire logic             tx_valid_o,
   input wire logic             is_mgr_o,
   input wire logic [7:0]       prio_o,
   input wire logic [DOM_W-1:0] my_id_o,
   input wire logic             id_valid_o,
   input wire logic             assign_ports_o,
   input wire logic [NDOM-1:0]  dom_map_o,
   input wire logic [NPORT-1:0] down_link_o,
   input wire logic [NPORT-1:0] iso_o,
   input wire logic [NPORT-1:0] class_n_ok_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   ////////////////////////////////////////////////////////////////////////////////
   // Quiet means no outbound event lately, so an inbound one cannot collide
   logic [1:0]    quiet_reg, quiet_next;
   logic [PW-1:0] up_reg, up_next;
   logic          quiet;
   always_comb begin
      quiet_next = tx_valid_o ? 2'h0 : ((quiet_reg == 2'h3) ? 2'h3 : quiet_reg + 2'h1);
      up_next    = low_seen_i ? low_port_i : up_reg;
   end
   always_ff @(posedge clk_i) begin
      quiet_reg <= sys_rst_i ? 2'h0 : quiet_next;
      up_reg    <= sys_rst_i ? 2'h0 : up_next;
   end
   assign quiet = (quiet_reg >= 2'h2) && !tx_valid_o;
   ////////////////////////////////////////////////////////////////////////////////
   property p_mgr; sel_done_i && is_principal_i |=> is_mgr_o && prio_o == MGR_PRIO
      && dom_map_o == '0; endproperty
   a_mgr: assert property (p_mgr) else $error("manager role");
   property p_self; sel_done_i && is_principal_i && have_prior_i
      && prior_id_i inside {[ID_FIRST:ID_LAST]} |-> ##2 tx_valid_o && tx_o.efp
      && tx_o.dom == $past(prior_id_i, 2) && my_id_o == tx_o.dom && assign_ports_o; endproperty
   a_self: assert property (p_self) else $error("self grant");
   property p_walk; sel_done_i && is_principal_i |-> ##3 (tx_valid_o && tx_o.aai
      && tx_o.port == 2'h0) ##1 (tx_valid_o && tx_o.aai && tx_o.port == 2'h1)
      ##1 (tx_valid_o && tx_o.aai && tx_o.port == 2'h2)
      ##1 (tx_valid_o && tx_o.aai && tx_o.port == 2'h3); endproperty
   a_walk: assert property (p_walk) else $error("aai walk");
   property p_grant; rx_i.rdi && is_mgr_o && quiet && !down_link_o[rx_i.port]
      && rx_i.dom inside {[ID_FIRST:ID_LAST]} && !dom_map_o[rx_i.dom] |=> tx_valid_o
      && tx_o.ans == FDD_ANS_ACC && tx_o.dom == $past(rx_i.dom)
      && tx_o.port == $past(rx_i.port) && down_link_o[tx_o.port]; endproperty
   a_grant: assert property (p_grant) else $error("rdi grant");
   property p_efp; tx_valid_o && tx_o.ans == FDD_ANS_ACC && is_mgr_o
      |-> dom_map_o[tx_o.dom] ##1 (tx_valid_o && tx_o.efp); endproperty
   a_efp: assert property (p_efp) else $error("efp after grant");
   property p_rjt; tx_valid_o && tx_o.ans == FDD_ANS_RJT
      |-> tx_o.rjt_reason == RJT_UNABLE && tx_o.rjt_expl == EXPL_NO_ID; endproperty
   a_rjt: assert property (p_rjt) else $error("reject codes");
   property p_ans; rx_i.aai && !is_mgr_o && quiet |=> tx_valid_o
      && tx_o.ans == FDD_ANS_ACC && tx_o.port == $past(rx_i.port); endproperty
   a_ans: assert property (p_ans) else $error("aai answer");
   property p_own; rx_i.aai && !is_mgr_o && !id_valid_o && quiet && rx_i.port == up_reg
      |-> ##2 tx_valid_o && tx_o.rdi && tx_o.port == up_reg; endproperty
   a_own: assert property (p_own) else $error("own rdi");
   property p_relay; rx_i.rdi && !is_mgr_o && id_valid_o && quiet |=> tx_valid_o
      && tx_o.rdi && tx_o.dom == $past(rx_i.dom) && tx_o.port == up_reg; endproperty
   a_relay: assert property (p_relay) else $error("relay");
   property p_iso; (param_bad_i | overlap_i) != '0 |=> class_n_ok_o == ~iso_o
      && (iso_o & $past(param_bad_i | overlap_i)) == $past(param_bad_i | overlap_i); endproperty
   a_iso: assert property (p_iso) else $error("isolation");
endmodule : fdd_core_sva
bind fdd_core fdd_core_sva i_sva (.*);
`default_nettype wire

// File: dv/fdd_core_tb.sv
// Purpose: Self-checking bench for fdd_core with a neighbour model
// Assumes: Peer model owns the inbound event port
// Notes:   Manager run twice to reach both self-grant and both reconfig kinds
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, ac) begin num_checks++; if ((ac) !== (ex)) begin failures++; \
   $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, ac); end end
module fdd_core_tb
   import fdd_pkg::*;
;
   logic clk_i = 1'h0, sys_rst_i = 1'h1, sel_done_i = 1'h0, is_principal_i = 1'h0;
   logic have_prior_i = 1'h0, low_seen_i = 1'h0, disruptive_i = 1'h0, no_mgr_i = 1'h0;
   logic cmd_valid = 1'h0, slow = 1'h0, tx_valid_o, is_mgr_o, id_valid_o, assign_ports_o;
   logic [7:0]       prior_id_i = 8'h44, gnt_dom = 8'h00, prio_o, my_id_o;
   logic [1:0]       low_port_i = 2'h0;
   logic [3:0]       param_bad_i = 4'h0, overlap_i = 4'h0, rcf_cancel_i = 4'h0;
   logic [3:0]       down_link_o, iso_o, class_n_ok_o;
   logic [NDOM-1:0]  dom_map_o;
   fdd_rx_t          cmd = '0, rx_i;
   fdd_tx_t          tx_o;
   int               failures = 0, num_checks = 0, cycles = 0;
   fdd_core i_dut (.*);
   fdd_peer i_peer (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .tx_i(tx_o), .tx_valid_i(tx_valid_o),
      .cmd_valid_i(cmd_valid), .cmd_i(cmd), .gnt_dom_i(gnt_dom), .slow_i(slow), .rx_o(rx_i));
   initial forever #12.5 clk_i = ~clk_i;
   // Whole run is about 120 cycles; the ceiling only catches a hang
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         failures++;
         stop_test();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic stop_test();
      if (failures == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : stop_test
   task automatic reset_dut();
      @(posedge clk_i);
      sys_rst_i <= 1'h1;
      repeat (2) @(posedge clk_i);
      sys_rst_i <= 1'h0;
   endtask : reset_dut
   task automatic wait_tx(output fdd_tx_t t);
      int n = 0;
      do begin
         @(posedge clk_i);
         #1;
         n++;
      end while (tx_valid_o !== 1'h1 && n < 20);
      t = (tx_valid_o === 1'h1) ? tx_o : '0;
   endtask : wait_tx
   task automatic send(input logic aai, input logic [7:0] d, input logic [1:0] p);
      @(posedge clk_i);
      cmd <= '{aai: aai, rdi: !aai, acc: 1'h0, dom: d, port: p};
      cmd_valid <= 1'h1;
      @(posedge clk_i);
      cmd_valid <= 1'h0;
   endtask : send
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_manager(input logic prior, input logic disr);
      fdd_tx_t    t;
      logic [7:0] lo = prior ? 8'h01 : 8'h02;
      logic [7:0] ex[4] = '{8'h10, lo, lo + 8'h01, 8'h10};
      logic [7:0] rq[4] = '{8'h10, 8'h10, 8'h00, 8'h10};
      logic [1:0] pt[4] = '{2'h1, 2'h2, 2'h3, 2'h1};
      reset_dut();
      @(posedge clk_i);
      sel_done_i <= 1'h1;
      is_principal_i <= 1'h1;
      have_prior_i <= prior;
      disruptive_i <= disr;
      @(posedge clk_i);
      sel_done_i <= 1'h0;
      #1;
      `CHK("prio_o", MGR_PRIO, prio_o)
      `CHK("is_mgr_o", 1'h1, is_mgr_o)
      `CHK("dom_map_o", {NDOM{1'h0}}, dom_map_o)
      wait_tx(t);
      `CHK("self_id", prior ? 8'h44 : ID_FIRST, t.dom)
      `CHK("self_efp", 1'h1, t.efp)
      `CHK("assign_ports_o", 1'h1, assign_ports_o)
      for (int p = 0; p < 4; p++) begin
         wait_tx(t);
         `CHK("aai_port", p[1:0], t.port)
         `CHK("aai", 1'h1, t.aai)
      end
      for (int i = 0; i < 4; i++) begin
         send(1'h0, rq[i], pt[i]);
         wait_tx(t);
         `CHK("grant_ans", FDD_ANS_ACC, t.ans)
         `CHK("grant_dom", ex[i], t.dom)
         `CHK("grant_port", pt[i], t.port)
         `CHK("map_bit", 1'h1, dom_map_o[ex[i]])
         wait_tx(t);
         `CHK("grant_efp", 1'h1, t.efp)
      end
      `CHK("down_link_o", 4'hE, down_link_o)
      send(1'h0, 8'h20, 2'h1);
      wait_tx(t);
      `CHK("bf", !disr, t.bf)
      `CHK("rcf", disr, t.rcf)
   endtask : t_manager
   task automatic t_requester();
      fdd_tx_t    t;
      logic [3:0] seen = 4'h0;
      reset_dut();
      @(posedge clk_i);
      sel_done_i <= 1'h1;
      is_principal_i <= 1'h0;
      low_seen_i <= 1'h1;
      low_port_i <= 2'h2;
      gnt_dom <= 8'h33;
      slow <= 1'h1;
      @(posedge clk_i);
      sel_done_i <= 1'h0;
      low_seen_i <= 1'h0;
      send(1'h1, 8'h00, 2'h1);
      wait_tx(t);
      `CHK("side_aai_ans", {FDD_ANS_ACC, 2'h1}, {t.ans, t.port})
      repeat (4) @(posedge clk_i);
      #1;
      `CHK("id_valid_o", 1'h0, id_valid_o)
      send(1'h1, 8'h00, 2'h2);
      wait_tx(t);
      `CHK("up_aai_ans", {FDD_ANS_ACC, 2'h2}, {t.ans, t.port})
      wait_tx(t);
      `CHK("own_rdi", 3'h6, {t.rdi, t.port})
      for (int i = 0; i < 3; i++) begin
         wait_tx(t);
         seen[t.port] = t.aai;
      end
      `CHK("my_id_o", {1'h1, 8'h33}, {id_valid_o, my_id_o})
      `CHK("aai_ports", 4'hB, seen)
      gnt_dom <= 8'h55;
      send(1'h0, 8'h55, 2'h0);
      wait_tx(t);
      `CHK("relay", {1'h1, 8'h55, 2'h2}, {t.rdi, t.dom, t.port})
      wait_tx(t);
      `CHK("relay_acc", {FDD_ANS_ACC, 8'h55, 2'h0}, {t.ans, t.dom, t.port})
      `CHK("down_link_o", 1'h1, down_link_o[0])
   endtask : t_requester
   task automatic t_iso();
      reset_dut();
      @(posedge clk_i);
      param_bad_i <= 4'h2;
      overlap_i <= 4'h4;
      @(posedge clk_i);
      param_bad_i <= 4'h0;
      overlap_i <= 4'h0;
      rcf_cancel_i <= 4'h2;
      #1;
      `CHK("iso_o", 4'h6, iso_o)
      `CHK("class_n_ok_o", 4'h9, class_n_ok_o)
      @(posedge clk_i);
      rcf_cancel_i <= 4'h8;
      overlap_i <= 4'h8;
      #1;
      `CHK("iso_o", 4'h4, iso_o)
      @(posedge clk_i);
      rcf_cancel_i <= 4'h0;
      overlap_i <= 4'h0;
      no_mgr_i <= 1'h1;
      #1;
      `CHK("iso_o", 4'hC, iso_o)
      @(posedge clk_i);
      no_mgr_i <= 1'h0;
      #1;
      `CHK("iso_o", 4'hF, iso_o)
   endtask : t_iso
   initial begin
      repeat (8) @(posedge clk_i);
      sys_rst_i <= 1'h0;
      @(posedge clk_i);
      #1;
      `CHK("reset", {8'hFF, 4'h0, 1'h0}, {prio_o, iso_o, id_valid_o})
      t_manager(1'h1, 1'h0);
      t_manager(1'h0, 1'h1);
      t_requester();
      t_iso();
      stop_test();
   end
endmodule : fdd_core_tb
`default_nettype wire
